/* hvp_byte_port.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Eight-bit two-way user bus, three-state or open-collector drivers.
// - Eight-bit two-way processor bus with three-state drivers.
// - Gate high leaves processor port idle; user port unaffected.
// - Data write from processor only while selected or select command high, strobe high, user write idle.
// - Select command with strobe compares byte to own address, sets or clears status.
// - Both commands low and selected: drive latch onto processor bus.
// - Both commands high with strobe: store data regardless, and update selection.
// - User write control low blocks processor data writes; select still works.
// - Processor writes and selects happen only while strobe is high.
// - Selection status holds until the next select operation or soft reset.
// - Synchronous variant: user write loads only while strobe high.
// - Asynchronous variant: user write loads whatever the strobe level.
// - User read control low with user write idle drives latch onto user bus, else released.
// - Simultaneous writes: user data wins, processor data ignored.
// - Data crossing ports is inverted; same port reads back unchanged.
// - Address compare uses all eight bits; default address all ones.
// - After reset: not selected, user outputs all high.
// - User port works whether or not the processor port is selected.
module hvp_byte_port #(
    parameter logic [7:0] DEV_ADDR = hvp_pkg::HVP_DEV_ADDR
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic soft_reset_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Processor-side port
    input wire logic port_gate_n_in,
    input wire logic host_select_cmd_in,
    input wire logic host_write_cmd_in,
    input wire logic strobe_clk_in,
    input wire logic [7:0] host_vector_bus_in,
    output logic [7:0] host_vector_bus_out,
    output logic host_vector_bus_oe_out,
    // User-side port
    input wire logic user_write_ctl_n_in,
    input wire logic user_read_ctl_n_in,
    input wire logic [7:0] user_data_lines_in,
    output logic [7:0] user_data_lines_out,
    output logic [7:0] user_data_lines_oe_out
);
    logic [5:0] ctl_s;
    logic [15:0] dat_s;
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic srst_q;
    logic wr_pend_q;
    logic [3:0] addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic [7:0] host_out_q;
    logic host_oe_q;
    logic [7:0] user_out_q;
    logic [7:0] user_oe_q;

    hvp_sel_if sel_if ();

    // Pins settle through three stages
    hvp_pin_sync #(
        .W(hvp_pkg::HVP_CTL_W),
        .RST(hvp_pkg::HVP_CTL_IDLE)
    ) u_ctl_sync (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in({user_read_ctl_n_in, user_write_ctl_n_in, strobe_clk_in,
                   host_write_cmd_in, host_select_cmd_in, port_gate_n_in}),
        .stable_out(ctl_s)
    );

    hvp_pin_sync #(
        .W(hvp_pkg::HVP_DAT_W),
        .RST(hvp_pkg::HVP_DAT_IDLE)
    ) u_dat_sync (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in({user_data_lines_in, host_vector_bus_in}),
        .stable_out(dat_s)
    );

    wire gate_w = ~ctl_s[hvp_pkg::HVP_C_GATE_N];
    wire sc_w = ctl_s[hvp_pkg::HVP_C_SEL];
    wire wc_w = ctl_s[hvp_pkg::HVP_C_WR];
    wire strb_w = ctl_s[hvp_pkg::HVP_C_STRB];
    wire uwr_w = ~ctl_s[hvp_pkg::HVP_C_UWR_N];
    wire urd_w = ~ctl_s[hvp_pkg::HVP_C_URD_N];
    wire [7:0] host_s = dat_s[7:0];
    wire [7:0] user_s = dat_s[15:8];
    wire async_w = ctrl_q[hvp_pkg::HVP_CTRL_ASYNC];
    wire oc_w = ctrl_q[hvp_pkg::HVP_CTRL_OC];
    wire clr_w = soft_reset_in | srst_q;
    wire selected_w = sel_if.selected;

    wire sel_op_w = gate_w & sc_w & strb_w;
    wire host_wr_w = gate_w & wc_w & strb_w & ~uwr_w & (sc_w | selected_w);
    wire user_wr_w = uwr_w & (async_w | strb_w);
    wire host_rd_w = gate_w & ~sc_w & ~wc_w & selected_w;
    wire user_drv_w = urd_w & ~uwr_w;

    assign sel_if.op = sel_op_w;
    assign sel_if.clear = clr_w;
    assign sel_if.bus_val = host_s;

    hvp_select #(
        .ADDR(DEV_ADDR)
    ) u_select (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .sel_if(sel_if.sel)
    );

    // Latch holds the byte as the user port sees it
    // user first, processor inverted
    always_comb begin
        latch_d = latch_q;
        if (clr_w) begin
            latch_d = hvp_pkg::HVP_LATCH_RST;
        end else if (user_wr_w) begin
            latch_d = user_s;
        end else if (host_wr_w) begin
            latch_d = ~host_s;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            latch_q <= hvp_pkg::HVP_LATCH_RST;
        end else begin
            latch_q <= latch_d;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            host_out_q <= hvp_pkg::HVP_ZEROS;
            host_oe_q <= 1'b0;
        end else begin
            host_out_q <= ~latch_q;
            host_oe_q <= host_rd_w & ~clr_w;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < hvp_pkg::HVP_W; gi++) begin : g_user
            wire bit_oe_w = user_drv_w & (~oc_w | ~latch_q[gi]);
            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    user_out_q[gi] <= 1'b1;
                    user_oe_q[gi] <= 1'b0;
                end else begin
                    user_out_q[gi] <= latch_q[gi] & ~oc_w;
                    user_oe_q[gi] <= bit_oe_w;
                end
            end
        end
    endgenerate

    // Bus slave: one-cycle address phase, zero-wait data phase
    wire ahb_go_w = hsel_in & htrans_in[1] & hready_in;
    wire [3:0] a_off_w = haddr_in[hvp_pkg::HVP_OFF_W-1:0];
    wire wr_ctrl_w = wr_pend_q & (addr_q == hvp_pkg::HVP_OFF_CTRL);
    wire [31:0] st_w = {16'h0000, latch_q, 7'h0, selected_w};
    wire [31:0] rd_mux_w =
        (a_off_w == hvp_pkg::HVP_OFF_CTRL) ? {30'h0, ctrl_q} :
        (a_off_w == hvp_pkg::HVP_OFF_STATUS) ? st_w :
        (a_off_w == hvp_pkg::HVP_OFF_ADDR) ? {24'h000000, DEV_ADDR} :
        32'h00000000;

    assign ctrl_d = wr_ctrl_w ? hwdata_in[1:0] : ctrl_q;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_pend_q <= 1'b0;
            addr_q <= hvp_pkg::HVP_OFF_CTRL;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b0;
        end else begin
            wr_pend_q <= ahb_go_w & hwrite_in;
            addr_q <= ahb_go_w ? a_off_w : addr_q;
            hrdata_q <= (ahb_go_w & ~hwrite_in) ? rd_mux_w : 32'h00000000;
            hreadyout_q <= 1'b1;
        end
    end

    // Soft reset bit self-clears
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q <= hvp_pkg::HVP_CTRL_RST;
            srst_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            srst_q <= wr_ctrl_w & hwdata_in[hvp_pkg::HVP_CTRL_SRST];
        end
    end

    assign hrdata_out = hrdata_q;
    assign hreadyout_out = hreadyout_q;
    assign hresp_out = hvp_pkg::HVP_HRESP_OKAY;
    assign host_vector_bus_out = host_out_q;
    assign host_vector_bus_oe_out = host_oe_q;
    assign user_data_lines_out = user_out_q;
    assign user_data_lines_oe_out = user_oe_q;

    // Checks
    sequence s_host_data;
        gate_w && wc_w && strb_w && !uwr_w && !clr_w;
    endsequence

    sequence s_both_cmds;
        gate_w && sc_w && wc_w && strb_w && !uwr_w && !clr_w;
    endsequence

    property p_gate_idle;
        @(posedge mclk_in) disable iff (!reset_n_in)
        !gate_w |-> !host_wr_w && !sel_op_w ##1 !host_vector_bus_oe_out;
    endproperty
    a_gate_idle: assert property (p_gate_idle)
        else $error("processor port active with gate high");

    property p_host_store;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (s_host_data and (!sc_w && selected_w)) |=> latch_q == ~$past(host_s);
    endproperty
    a_host_store: assert property (p_host_store)
        else $error("selected processor write not stored inverted");

    property p_unsel_store;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (gate_w && !sc_w && !selected_w && !user_wr_w && !clr_w)
            |=> $stable(latch_q);
    endproperty
    a_unsel_store: assert property (p_unsel_store)
        else $error("latch changed while not selected");

    property p_select;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (sel_op_w && !clr_w) |=> selected_w == ($past(host_s) == DEV_ADDR);
    endproperty
    a_select: assert property (p_select)
        else $error("select status disagrees with address compare");

    property p_host_read;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (host_rd_w && !clr_w) |=> host_vector_bus_oe_out
            && host_vector_bus_out == ~$past(latch_q);
    endproperty
    a_host_read: assert property (p_host_read)
        else $error("selected read not driven with inverted latch");

    property p_both_cmds;
        @(posedge mclk_in) disable iff (!reset_n_in)
        s_both_cmds |=> latch_q == ~$past(host_s)
            && selected_w == ($past(host_s) == DEV_ADDR);
    endproperty
    a_both_cmds: assert property (p_both_cmds)
        else $error("combined data and address write failed");

    property p_user_block;
        @(posedge mclk_in) disable iff (!reset_n_in)
        uwr_w |-> !host_wr_w;
    endproperty
    a_user_block: assert property (p_user_block)
        else $error("processor write during user write");

    property p_strobe_low;
        @(posedge mclk_in) disable iff (!reset_n_in)
        !strb_w && !clr_w && !user_wr_w |=> $stable(latch_q) && $stable(selected_w);
    endproperty
    a_strobe_low: assert property (p_strobe_low)
        else $error("processor input with strobe low");

    property p_sel_hold;
        @(posedge mclk_in) disable iff (!reset_n_in)
        !sel_op_w && !clr_w |=> selected_w == $past(selected_w);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("select status changed without select");

    property p_user_load;
        @(posedge mclk_in) disable iff (!reset_n_in)
        uwr_w && (strb_w || async_w) && !clr_w |=> latch_q == $past(user_s);
    endproperty
    a_user_load: assert property (p_user_load)
        else $error("user write did not win the latch");

    property p_user_sync;
        @(posedge mclk_in) disable iff (!reset_n_in)
        uwr_w && !strb_w && !async_w && !clr_w |=> $stable(latch_q);
    endproperty
    a_user_sync: assert property (p_user_sync)
        else $error("synchronous user load with strobe low");

    property p_user_drive;
        @(posedge mclk_in) disable iff (!reset_n_in)
        user_drv_w && !oc_w |=> user_data_lines_oe_out == hvp_pkg::HVP_ONES
            && user_data_lines_out == $past(latch_q);
    endproperty
    a_user_drive: assert property (p_user_drive)
        else $error("user read not driving latch");

    property p_user_release;
        @(posedge mclk_in) disable iff (!reset_n_in)
        !user_drv_w |=> user_data_lines_oe_out == hvp_pkg::HVP_ZEROS;
    endproperty
    a_user_release: assert property (p_user_release)
        else $error("user bus driven while released");

    property p_soft_reset;
        @(posedge mclk_in) disable iff (!reset_n_in)
        clr_w |=> !selected_w && latch_q == hvp_pkg::HVP_LATCH_RST;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not restore start state");
endmodule

/* hvp_pkg.sv */
package hvp_pkg;
    // Byte port geometry
    localparam int unsigned HVP_W = 8;
    localparam logic [7:0] HVP_DEV_ADDR = 8'hff;
    localparam logic [7:0] HVP_LATCH_RST = 8'hff;
    localparam logic [7:0] HVP_ONES = 8'hff;
    localparam logic [7:0] HVP_ZEROS = 8'h00;

    // Pin synchroniser
    localparam int unsigned HVP_SYNC_STAGES = 3;
    localparam int unsigned HVP_CTL_W = 6;
    localparam logic [5:0] HVP_CTL_IDLE = 6'h31;
    localparam int unsigned HVP_C_GATE_N = 0;
    localparam int unsigned HVP_C_SEL = 1;
    localparam int unsigned HVP_C_WR = 2;
    localparam int unsigned HVP_C_STRB = 3;
    localparam int unsigned HVP_C_UWR_N = 4;
    localparam int unsigned HVP_C_URD_N = 5;
    localparam int unsigned HVP_DAT_W = 16;
    localparam logic [15:0] HVP_DAT_IDLE = 16'h0000;

    // Register map (byte offsets)
    localparam logic [3:0] HVP_OFF_CTRL = 4'h0;
    localparam logic [3:0] HVP_OFF_STATUS = 4'h4;
    localparam logic [3:0] HVP_OFF_ADDR = 4'h8;
    localparam int unsigned HVP_OFF_W = 4;

    // Control register fields
    localparam int unsigned HVP_CTRL_ASYNC = 0;
    localparam int unsigned HVP_CTRL_OC = 1;
    localparam int unsigned HVP_CTRL_SRST = 2;
    localparam logic [1:0] HVP_CTRL_RST = 2'h0;

    // Status register fields
    localparam int unsigned HVP_ST_SEL = 0;
    localparam int unsigned HVP_ST_LATCH = 8;

    // AHB-Lite codes
    localparam logic HVP_HRESP_OKAY = 1'b0;
endpackage

/* hvp_sel_if.sv */
`timescale 1ns/10ps
interface hvp_sel_if;
    logic op;
    logic clear;
    logic [7:0] bus_val;
    logic selected;

    modport ctl (output op, output clear, output bus_val, input selected);
    modport sel (input op, input clear, input bus_val, output selected);
endinterface

/* hvp_pin_sync.sv */
`timescale 1ns/10ps
module hvp_pin_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Pins and settled copy
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] stable_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] stable_q;

    // A bit counts once stages two and three agree
    wire [W-1:0] agree_w = ~(s2_q ^ s3_q);
    wire [W-1:0] stable_d = (stable_q & ~agree_w) | (s3_q & agree_w);

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            stable_q <= RST;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= stable_d;
        end
    end

    assign stable_out = stable_q;
endmodule

/* hvp_select.sv */
`timescale 1ns/10ps
module hvp_select #(
    parameter logic [7:0] ADDR = hvp_pkg::HVP_DEV_ADDR
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Select request and result
    hvp_sel_if.sel sel_if
);
    logic selected_q;
    logic selected_d;

    // All eight bits compared against the fixed address
    wire match_w = (sel_if.bus_val == ADDR);

    always_comb begin
        selected_d = selected_q;
        if (sel_if.clear) begin
            selected_d = 1'b0;
        end else if (sel_if.op) begin
            selected_d = match_w;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            selected_q <= 1'b0;
        end else begin
            selected_q <= selected_d;
        end
    end

    assign sel_if.selected = selected_q;
endmodule

/* hvp_far_end.sv */
`timescale 1ns/10ps
module hvp_far_end (
    // Clock
    input wire logic mclk_in,
    // Processor side
    input wire logic host_drv_in,
    input wire logic [7:0] host_val_in,
    input wire logic host_oe_in,
    input wire logic [7:0] host_out_in,
    output logic [7:0] host_wire_out,
    // User side
    input wire logic user_drv_in,
    input wire logic [7:0] user_val_in,
    input wire logic oc_in,
    input wire logic [7:0] user_oe_in,
    input wire logic [7:0] user_out_in,
    output logic [7:0] user_wire_out
);
    logic [7:0] host_last_q = 8'h00;
    logic [7:0] user_last_q = 8'h00;

    assign host_wire_out = host_drv_in ? host_val_in : (host_oe_in ? host_out_in : ~host_last_q);

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            user_wire_out[i] = user_drv_in ? user_val_in[i] :
                (user_oe_in[i] ? user_out_in[i] : (oc_in ? 1'b1 : ~user_last_q[i]));
        end
    end

    always_ff @(posedge mclk_in) begin
        host_last_q <= host_wire_out;
        user_last_q <= user_wire_out;
    end
endmodule

/* tb.sv */
`timescale 1ns/10ps
module tb;
    localparam logic [7:0] DEV = 8'h5a;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic soft_reset_in = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic gate_n = 1'b1, sc = 1'b0, wc = 1'b0, strb = 1'b0;
    logic uwr_n = 1'b1, urd_n = 1'b1, h_drv = 1'b0, u_drv = 1'b0, oc_m = 1'b0;
    logic [7:0] h_val = 8'h00, u_val = 8'h00;
    logic [7:0] h_out, u_out, u_oe, h_wire, u_wire;
    logic h_oe;
    int n_mismatch = 0;
    int n_tests = 0;
    int latch = 255;
    int sel = 0;
    int async_m = 0;
    logic [31:0] lf = 32'hdd81;
    logic [31:0] rd;

    always #12.5 mclk_in = ~mclk_in;

    hvp_byte_port #(.DEV_ADDR(DEV)) hvp_byte_port_inst (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .soft_reset_in(soft_reset_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
        .port_gate_n_in(gate_n), .host_select_cmd_in(sc), .host_write_cmd_in(wc),
        .strobe_clk_in(strb), .host_vector_bus_in(h_wire), .host_vector_bus_out(h_out),
        .host_vector_bus_oe_out(h_oe), .user_write_ctl_n_in(uwr_n),
        .user_read_ctl_n_in(urd_n), .user_data_lines_in(u_wire),
        .user_data_lines_out(u_out), .user_data_lines_oe_out(u_oe));

    hvp_far_end hvp_far_end_inst (
        .mclk_in(mclk_in), .host_drv_in(h_drv), .host_val_in(h_val), .host_oe_in(h_oe),
        .host_out_in(h_out), .host_wire_out(h_wire), .user_drv_in(u_drv),
        .user_val_in(u_val), .oc_in(oc_m), .user_oe_in(u_oe), .user_out_in(u_out),
        .user_wire_out(u_wire));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge mclk_in);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk_in); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk_in); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, 0);
    endtask

    task automatic op(input logic g, s, w, k, uw, input logic [7:0] hv, uv);
        logic hw;
        @(posedge mclk_in);
        gate_n <= g;
        sc <= s;
        wc <= w;
        strb <= k;
        uwr_n <= uw;
        urd_n <= uw;
        h_drv <= 1'b1;
        h_val <= hv;
        u_drv <= !uw;
        u_val <= uv;
        repeat (8) @(posedge mclk_in);
        if (!uw) chk(u_oe, 0);
        gate_n <= 1'b1;
        sc <= 1'b0;
        wc <= 1'b0;
        strb <= 1'b0;
        uwr_n <= 1'b1;
        urd_n <= 1'b1;
        h_drv <= 1'b0;
        u_drv <= 1'b0;
        repeat (8) @(posedge mclk_in);
        hw = !g && k && w && uw && (s || sel != 0);
        if (!uw && (async_m != 0 || k))
            latch = uv;
        else if (hw)
            latch = 8'(~hv);
        if (!g && k && s)
            sel = (hv == DEV);
    endtask

    task automatic look;
        @(posedge mclk_in);
        gate_n <= 1'b0;
        urd_n <= 1'b0;
        repeat (8) @(posedge mclk_in);
        chk(u_wire, latch);
        chk(h_oe, sel);
        if (sel != 0) chk(h_wire, ~latch & 8'hff);
        if (oc_m) chk(u_oe, ~latch & 8'hff);
        gate_n <= 1'b1;
        urd_n <= 1'b1;
        repeat (6) @(posedge mclk_in);
        chk(h_oe, 0);
        if (!oc_m) chk(u_oe, 0);
        ahb(1'b0, 32'h4, 32'h0);
        chk(rd, {16'h0, latch[7:0], 7'h0, sel[0]});
    endtask

    task automatic complete_run;
        $display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #2000000;
        n_mismatch++;
        complete_run;
    end

    initial begin
        repeat (3) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
        look;
        ahb(1'b0, 32'h8, 32'h0);
        chk(rd, DEV);
        ahb(1'b0, 32'hc, 32'h0);
        chk(rd, 0);
        ahb(1'b1, 32'h4, 32'hffffffff);
        look;
        op(0, 1, 0, 1, 1, DEV, 0);
        look;
        for (int i = 0; i < 8; i++) begin
            op(0, 1, 0, 1, 1, DEV, 0);
            op(0, 1, 0, 1, 1, DEV ^ (8'h01 << i), 0);
            look;
        end
        op(0, 1, 0, 1, 1, DEV, 0);
        lf = lfsr(lf);
        op(0, 0, 1, 1, 1, lf[7:0], 0);
        look;
        op(0, 0, 1, 0, 1, lf[15:8], 0);
        op(0, 1, 0, 0, 1, 8'h00, 0);
        look;
        op(1, 1, 1, 1, 1, lf[15:8], 0);
        look;
        op(0, 0, 1, 1, 0, lf[7:0], lf[15:8]);
        look;
        op(0, 1, 1, 1, 0, 8'h00, lf[23:16]);
        look;
        op(0, 1, 1, 1, 1, DEV, 0);
        look;
        op(0, 1, 1, 1, 1, lf[23:16], 0);
        look;
        op(1, 0, 0, 0, 0, 8'h00, lf[31:24]);
        look;
        ahb(1'b1, 32'h0, 32'h1);
        async_m = 1;
        ahb(1'b0, 32'h0, 32'h0);
        chk(rd, 1);
        op(1, 0, 0, 0, 0, 8'h00, lf[7:0] ^ 8'h3c);
        look;
        ahb(1'b1, 32'h0, 32'h2);
        async_m = 0;
        oc_m = 1'b1;
        look;
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            op(lf[0], lf[1], lf[2], lf[3], lf[4], lf[5] ? DEV : lf[15:8], lf[23:16]);
            look;
        end
        ahb(1'b1, 32'h0, 32'h4);
        oc_m = 1'b0;
        latch = 255;
        sel = 0;
        look;
        op(0, 1, 0, 1, 1, DEV, 0);
        @(posedge mclk_in);
        soft_reset_in <= 1'b1;
        @(posedge mclk_in);
        soft_reset_in <= 1'b0;
        latch = 255;
        sel = 0;
        look;
        complete_run;
    end
endmodule
